// file: src/cpu_bus_port_defines.vh
/*
  Constants for the processor bus port: reset values of the pin-facing
  registers and of the read data handed to the core.
  Assumes it is included by bare name from the port module only.
*/
`ifndef CPU_BUS_PORT_DEFINES_VH
`define CPU_BUS_PORT_DEFINES_VH

// Address shown on the address outputs while in reset
`define BUS_ADDR_RST   16'h0000
// Write data register value while in reset
`define BUS_WDATA_RST  8'h00
// Direction output in reset: high means read, bus not driven
`define BUS_RW_RST     1'b1
// Data driver enable in reset
`define BUS_OE_RST     1'b0
// Read data value handed to the core in reset
`define BUS_RDATA_RST  8'h00
// Opcode fetch marker in reset
`define BUS_SYNC_RST   1'b0

`endif

// file: src/cpu_bus_ready_halt_port.v
/*
  External bus port of an 8-bit processor: address outputs, three-state
  data lines with external driver enable, direction output, opcode fetch
  marker and the halt request (ready) input that stretches read cycles.
  Assumes the two non-overlapping bus phases, the ready and driver enable
  inputs and the data lines arrive from pins, asynchronous to clock, and
  that the core on the user side waits for core_done before it changes
  its request.
  Ready, enable and data are seen two clocks late through the synchronisers.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cpu_bus_port_defines.vh"

module cpu_bus_ready_halt_port #(
  parameter ADDR_W = 16,
  parameter DATA_W = 8
) (
  input  wire              clock,
  input  wire              rstn,
  input  wire              phi1,
  input  wire              phi2,
  input  wire              ready,
  input  wire              data_output_enable,
  input  wire [DATA_W-1:0] data_lines_in,
  input  wire [ADDR_W-1:0] core_addr,
  input  wire              core_read,
  input  wire [DATA_W-1:0] core_wdata,
  input  wire              core_fetch,
  output reg  [ADDR_W-1:0] address_outputs,
  output reg  [DATA_W-1:0] data_lines_out,
  output reg               data_lines_oe,
  output reg               read_write,
  output reg               sync_out,
  output reg  [DATA_W-1:0] core_rdata,
  output reg               core_done,
  output reg               halted
);

  localparam [2:0] S_WAIT = 3'b001;
  localparam [2:0] S_PH1  = 3'b010;
  localparam [2:0] S_PH2  = 3'b100;

  // Pin synchronisers: stage one is read only by stage two
  reg              phi1_s1_ff;
  reg              phi1_s2_ff;
  reg              phi1_d_ff;
  reg              phi2_s1_ff;
  reg              phi2_s2_ff;
  reg              phi2_d_ff;
  reg              rdy_s1_ff;
  reg              rdy_s2_ff;
  reg              doe_s1_ff;
  reg              doe_s2_ff;
  reg [DATA_W-1:0] din_s1_ff;
  reg [DATA_W-1:0] din_s2_ff;

  reg [2:0]        state_ff;
  reg [2:0]        nxt_state;
  reg              load_ff;
  reg              nxt_load;
  reg              nxt_done;
  reg              nxt_halted;

  // A write always ends; a read ends only with ready seen high
  function cycle_may_end;
    input rw;
    input rdy;
    begin
      cycle_may_end = ~rw | rdy;
    end
  endfunction

  wire phi1_rise = phi1_s2_ff & ~phi1_d_ff;
  wire phi2_fall = ~phi2_s2_ff & phi2_d_ff;
  // Only read cycles may stall; a write always runs to its end
  wire stall_now = ~cycle_may_end(read_write, rdy_s2_ff);

  // Direction as it stands after this edge, so the drivers drop at the
  // very edge a read begins instead of one clock later
  wire load_now  = (state_ff == S_WAIT) & phi1_rise & load_ff;
  wire rw_next   = load_now ? core_read : read_write;

  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      phi1_s1_ff <= 1'b0;
      phi1_s2_ff <= 1'b0;
      phi1_d_ff  <= 1'b0;
      phi2_s1_ff <= 1'b0;
      phi2_s2_ff <= 1'b0;
      phi2_d_ff  <= 1'b0;
      rdy_s1_ff  <= 1'b1;
      rdy_s2_ff  <= 1'b1;
      doe_s1_ff  <= 1'b0;
      doe_s2_ff  <= 1'b0;
      din_s1_ff  <= {DATA_W{1'b0}};
      din_s2_ff  <= {DATA_W{1'b0}};
    end else begin
      phi1_s1_ff <= phi1;
      phi1_s2_ff <= phi1_s1_ff;
      phi1_d_ff  <= phi1_s2_ff;
      phi2_s1_ff <= phi2;
      phi2_s2_ff <= phi2_s1_ff;
      phi2_d_ff  <= phi2_s2_ff;
      rdy_s1_ff  <= ready;
      rdy_s2_ff  <= rdy_s1_ff;
      doe_s1_ff  <= data_output_enable;
      doe_s2_ff  <= doe_s1_ff;
      din_s1_ff  <= data_lines_in;
      din_s2_ff  <= din_s1_ff;
    end
  end

  // Cycle sequencer: phase one start, phase two end
  always @* begin
    nxt_state  = state_ff;
    nxt_load   = load_ff;
    nxt_done   = 1'b0;
    nxt_halted = halted;
    case (state_ff)
      S_WAIT: begin
        if (phi1_rise) begin
          nxt_state = S_PH1;
          nxt_load  = 1'b0;
        end
      end
      S_PH1: begin
        // Ready falling during or with phase one halts a read
        if (stall_now) begin
          nxt_halted = 1'b1;
        end
        if (phi2_s2_ff) begin
          nxt_state = S_PH2;
        end
      end
      S_PH2: begin
        if (phi2_fall) begin
          nxt_state = S_WAIT;
          // Ready sampled at the end of phase two, stable by contract
          if (stall_now) begin
            nxt_halted = 1'b1;
          end else begin
            nxt_halted = 1'b0;
            nxt_done   = 1'b1;
            nxt_load   = 1'b1;
          end
        end
      end
      default: begin
        nxt_state = S_WAIT;
      end
    endcase
  end

  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_ff  <= S_WAIT;
      load_ff   <= 1'b1;
      core_done <= 1'b0;
      halted    <= 1'b0;
    end else begin
      state_ff  <= nxt_state;
      load_ff   <= nxt_load;
      core_done <= nxt_done;
      halted    <= nxt_halted;
    end
  end

  // A halted read keeps its address, direction and marker, so the
  // same read repeats each period until ready returns high
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      address_outputs <= `BUS_ADDR_RST;
      read_write      <= `BUS_RW_RST;
      sync_out        <= `BUS_SYNC_RST;
      data_lines_out  <= `BUS_WDATA_RST;
    end else if (load_now) begin
      address_outputs <= core_addr;
      read_write      <= core_read;
      sync_out        <= core_fetch;
      data_lines_out  <= core_wdata;
    end
  end

  // Drivers: write cycle and external enable both needed; the enable
  // is expected to follow phase two, which times the write data
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      data_lines_oe <= `BUS_OE_RST;
    end else begin
      data_lines_oe <= ~rw_next & doe_s2_ff;
    end
  end

  // Read data is taken at the phase two end of a completed read
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      core_rdata <= `BUS_RDATA_RST;
    end else if (state_ff == S_PH2 && phi2_fall &&
                 read_write && cycle_may_end(read_write, rdy_s2_ff)) begin
      core_rdata <= din_s2_ff;
    end
  end

  // Phases are assumed non-overlapping; overlap would end PH1 early

endmodule

`default_nettype wire

// file: test/bus_port_properties.sv
/* Pin checker for the bus port. Bound to every port instance below. */
`timescale 1ns/1ps
`default_nettype none
module bus_port_checker (
  input wire logic        clock,
  input wire logic        rstn,
  input wire logic        data_output_enable,
  input wire logic [15:0] address_outputs,
  input wire logic        data_lines_oe,
  input wire logic        read_write,
  input wire logic        sync_out,
  input wire logic [7:0]  core_rdata,
  input wire logic        core_done,
  input wire logic        halted
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rstn);
  property p_rd; read_write && $past(read_write) |-> !data_lines_oe; endproperty
  a_rd: assert property (p_rd) else $error("driven in read");
  property p_en; (!data_output_enable) [*4] |=> !data_lines_oe; endproperty
  a_en: assert property (p_en) else $error("driven, enable low");
  property p_pulse; core_done |=> !core_done; endproperty
  a_pulse: assert property (p_pulse) else $error("done too long");
  property p_wr; !read_write |-> !halted; endproperty
  a_wr: assert property (p_wr) else $error("write halted");
  property p_hold; halted && $past(halted) |-> $stable({address_outputs, read_write}); endproperty
  a_hold: assert property (p_hold) else $error("moved in halt");
  property p_step; halted && $past(halted) |-> $stable(sync_out); endproperty
  a_step: assert property (p_step) else $error("marker moved");
  property p_done; core_done |-> !halted; endproperty
  a_done: assert property (p_done) else $error("done in halt");
  property p_rdata; $changed(core_rdata) |-> core_done && read_write; endproperty
  a_rdata: assert property (p_rdata) else $error("stray data");
  c_halt: cover property ($rose(halted));
  c_rd: cover property (core_done && read_write);
  c_wr: cover property (core_done && !read_write);
endmodule
bind cpu_bus_ready_halt_port bus_port_checker chk (.clock, .rstn, .data_output_enable,
  .address_outputs, .data_lines_oe, .read_write, .sync_out, .core_rdata, .core_done, .halted);
`default_nettype wire

// file: test/bus_far_side.sv
/* Far side: phase pins, ready logic, memory. Runs on the bench clock. */
`timescale 1ns/1ps
`default_nettype none
module bus_far_side (
  input  wire logic [15:0] address_outputs,
  input  wire logic        clock,
  input  wire logic [7:0]  data_lines_out,
  input  wire logic        data_lines_oe,
  input  wire logic        read_write,
  output logic             phi1,
  output logic             phi2,
  output logic             ready,
  output logic             data_output_enable,
  output logic [7:0]       data_lines_in,
  output logic [7:0]       last_write
);
  int left = 0;
  wire logic [7:0] mem = address_outputs[7:0] ^ address_outputs[15:8];
  // Released bus in a write cycle shows the inverse so a stale value cannot pass
  assign data_lines_in = data_lines_oe ? data_lines_out : (read_write ? mem : ~mem);
  assign data_output_enable = phi2;
  always @(posedge clock) if (data_lines_oe) last_write <= data_lines_out;
  initial begin
    {phi1, phi2, ready} = 3'b001;
    forever begin
      ready = (left == 0);
      if (left > 0) left--;
      phi1 = 1'b1;
      repeat (7) @(posedge clock);
      #1 phi1 = 1'b0;
      repeat (2) @(posedge clock);
      #1 phi2 = 1'b1;
      repeat (7) @(posedge clock);
      #1 phi2 = 1'b0;
      repeat (8) @(posedge clock);
      #1;
    end
  end
endmodule
`default_nettype wire

// file: test/testbench.sv
/* Bench for the bus port; bus_far_side plays memory and ready logic. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clock = 0, rstn = 0, core_read = 1, core_fetch = 0, oe;
  logic [15:0] core_addr = 16'h0000;
  logic [7:0] core_wdata = 8'h00;
  wire logic phi1, phi2, ready, data_output_enable, data_lines_oe, read_write, sync_out;
  wire logic core_done, halted;
  wire logic [15:0] address_outputs;
  wire logic [7:0] data_lines_in, data_lines_out, core_rdata, last_write;
  int failures = 0, total_checks = 0, hc;
  cpu_bus_ready_halt_port dut (.clock, .rstn, .phi1, .phi2, .ready, .data_output_enable,
    .data_lines_in, .core_addr, .core_read, .core_wdata, .core_fetch, .address_outputs,
    .data_lines_out, .data_lines_oe, .read_write, .sync_out, .core_rdata, .core_done, .halted);
  bus_far_side far (.clock, .address_outputs, .data_lines_out, .data_lines_oe, .read_write,
    .phi1, .phi2, .ready, .data_output_enable, .data_lines_in, .last_write);
  initial forever #2 clock = ~clock;
  task chk(input logic ok, input string m);
    total_checks++;
    if (ok !== 1'b1) begin
      failures++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask
  task op(input logic [15:0] a, input logic rd, fe, input logic [7:0] d, input int st);
    int n;
    n = 0;
    hc = 0;
    oe = 0;
    {core_addr, core_read, core_fetch, core_wdata} = {a, rd, fe, d};
    if (st > 0) far.left = st;
    do begin
      @(posedge clock);
      #1 n++;
      if (halted === 1'b1) hc++;
      if (halted === 1'b1) chk(address_outputs === a && read_write === 1'b1 && sync_out === fe,
        "halt hold");
      if (data_lines_oe === 1'b1) oe = 1;
    end while (core_done !== 1'b1 && n < 200);
    chk(core_done === 1'b1, "no done");
    chk(address_outputs === a && read_write === rd && sync_out === fe, "pins");
    if (rd) chk(core_rdata === (a[7:0] ^ a[15:8]), "read data");
  endtask
  task t_reset;
    repeat (12) @(posedge clock);
    #1 chk({address_outputs, read_write, data_lines_oe, core_done, halted} === 20'h00008,
      "reset");
    rstn = 1;
    op(16'h0000, 1, 0, 8'h00, 0);
    $display("reset test done");
  endtask
  task t_rw;
    op(16'h12a5, 1, 0, 8'h00, 0);
    op(16'h3c01, 0, 0, 8'h96, 2);
    chk(hc == 0 && oe === 1'b1 && last_write === 8'h96, "write");
    op(16'h3c01, 1, 0, 8'h00, 0);
    chk(hc > 0, "deferred halt");
    $display("read write test done");
  endtask
  task t_halt;
    op(16'hbeef, 1, 1, 8'h00, 2);
    chk(hc >= 40 && hc <= 72, "halt length");
    $display("halt test done");
  endtask
  task results;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    t_reset;
    t_rw;
    t_halt;
    results;
  end
  initial begin
    #20000;
    failures++;
    results;
  end
endmodule
`default_nettype wire
